// ===== pkg/spu_uart_map.svh
// Register offsets, field positions, reset values and timing counts of the serial port.
// Assumes an 8-bit register address space; the file is included by its bare name.
`ifndef SPU_UART_MAP_SVH
`define SPU_UART_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPU_ADDR_CTRL 8'h98
`define SPU_ADDR_DATA 8'h99
`define SPU_ADDR_IRQ_STAT 8'h9a
`define SPU_ADDR_IRQ_MASK 8'h9b
`define SPU_ADDR_REL_LOW 8'haa
`define SPU_ADDR_REL_HIGH 8'hba
`define SPU_ADDR_SRC_SEL 8'hd8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SPU_RST_CTRL 8'h00
`define SPU_RST_DATA 8'h00
`define SPU_RST_REL_LOW 8'hd9
`define SPU_RST_REL_HIGH 8'h03
`define SPU_RST_SRC_SEL 8'h00
`define SPU_RST_IRQ 2'h0

// ----------------------------------------
// Control, source select and reload high register fields
// ----------------------------------------
`define SPU_MODE_HI 7
`define SPU_MODE_LO 6
`define SPU_RX_EN 4
`define SPU_TX_NINTH 3
`define SPU_RX_NINTH 2
`define SPU_TX_DONE 1
`define SPU_RX_DONE 0
`define SPU_SRC_INT 7
`define SPU_REL_HIGH_MSB 1

// ----------------------------------------
// Interrupt status and mask fields
// ----------------------------------------
`define SPU_IRQ_TX 1
`define SPU_IRQ_RX 0

// ----------------------------------------
// Timing counts: core clock cycles, prescaler steps, 16x phases and bit indexes
// ----------------------------------------
`define SPU_SHIFT_DIV 12
`define SPU_SHIFT_HALF 3'h5
`define SPU_PRE_DBL 2'h1
`define SPU_PRE_NORM 2'h3
`define SPU_REL_TOP 10'h3ff
`define SPU_PH_MID 4'h7
`define SPU_PH_END 4'hf
`define SPU_BITS_8 4'h7
`define SPU_BITS_9 4'h8

`endif

// ===== pkg/spu_pkg.sv
// Types shared by the serial port modules.
// Assumes the map header supplies the numeric constants.
package spu_pkg;

	typedef enum logic [1:0] {
		SPU_MODE_SHIFT,
		SPU_MODE_UART8,
		SPU_MODE_UART9_FIX,
		SPU_MODE_UART9_VAR
	} spu_mode_type;

	typedef enum logic [2:0] {
		TX_IDLE,
		TX_START,
		TX_DATA,
		TX_STOP,
		TX_SHIFT
	} spu_tx_state_type;

	typedef enum logic [1:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} spu_rx_state_type;

	typedef struct packed {
		logic [1:0] pre;
		logic [9:0] cnt;
		logic t1_div;
		logic [2:0] half_cnt;
		logic tick16;
		logic half;
	} spu_baud_state_type;

	typedef struct packed {
		spu_tx_state_type tx_state;
		logic [3:0] tx_ph;
		logic [3:0] tx_bits;
		logic [8:0] tx_shift;
		logic shift_rx;
		spu_rx_state_type rx_state;
		logic [3:0] rx_ph;
		logic [3:0] rx_bits;
		logic [8:0] rx_shift;
		logic rx_prev;
		logic [7:0] rx_buf;
		logic [7:0] ctrl;
		logic [7:0] rel_low;
		logic [7:0] rel_high;
		logic src_int;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic [7:0] rdata;
		logic tx_line;
		logic rx_line;
		logic rx_oe;
	} spu_state_type;

endpackage

// ===== rtl/spu_baud.sv
// Bit rate generator of the serial port: a 16x tick for the UART modes and a
// half-bit tick for shift-register mode. Assumes one core clock and synchronous inputs.
`timescale 1ns/1ps
`include "spu_uart_map.svh"

module spu_baud (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [1:0] mode_i,
	input wire logic rate_double_i,
	input wire logic internal_sel_i,
	input wire logic [9:0] reload_i,
	input wire logic timer1_overflow_i,
	output logic tick16_o,
	output logic half_o
);

	spu_pkg::spu_baud_state_type s;
	spu_pkg::spu_baud_state_type next_s;

	function automatic logic pre_end(input logic [1:0] pre, input logic dbl);
		pre_end = (pre == (dbl ? `SPU_PRE_DBL : `SPU_PRE_NORM));
	endfunction

	always_comb begin
		next_s = s;
		next_s.tick16 = 1'b0;
		next_s.half = 1'b0;
		// Generator idles at the reload value so its first bit is not a full wrap long
		if (!internal_sel_i || mode_i == 2'(spu_pkg::SPU_MODE_UART9_FIX)) begin
			next_s.cnt = reload_i;
		end
		// Shift-register mode: a full bit is two halves of the core clock / 12
		if (s.half_cnt == `SPU_SHIFT_HALF) begin
			next_s.half_cnt = 3'h0;
			next_s.half = 1'b1;
		end else begin
			next_s.half_cnt = s.half_cnt + 3'h1;
		end
		if (mode_i == 2'(spu_pkg::SPU_MODE_UART9_FIX)) begin
			// Fixed rate: 16x tick every 4 or 2 clocks, bit at /64 or /32 RULE_02
			next_s.pre = pre_end(s.pre, rate_double_i) ? 2'h0 : s.pre + 2'h1;
			next_s.tick16 = pre_end(s.pre, rate_double_i); // RULE_13
		end else if (internal_sel_i) begin
			// Internal generator: bit = 64 * (1024 - reload) / 2^double clocks
			next_s.pre = pre_end(s.pre, rate_double_i) ? 2'h0 : s.pre + 2'h1; // RULE_12
			if (pre_end(s.pre, rate_double_i)) begin
				if (s.cnt == `SPU_REL_TOP) begin
					next_s.cnt = reload_i; // RULE_10
					next_s.tick16 = 1'b1; // RULE_11
				end else begin
					next_s.cnt = s.cnt + 10'h1;
				end
			end
		end else if (timer1_overflow_i) begin
			// Timer 1 overflow: bit = 32 overflows, or 16 when doubled
			next_s.t1_div = ~s.t1_div; // RULE_11
			next_s.tick16 = rate_double_i | s.t1_div; // RULE_13
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			s <= '0;
		end else begin
			s <= next_s; // RULE_14
		end
	end

	assign tick16_o = s.tick16;
	assign half_o = s.half;

endmodule

// ===== rtl/spu_uart.sv
// Serial port: shift-register mode and three UART modes, with its register file
// on a plain address/strobe port and one level interrupt.
// Assumes the power-control rate-double flag and timer 1 overflow come from outside.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "spu_uart_map.svh"

// Summary of operation
// (RULE_01) Mode field picks shift register or UARTs
// (RULE_02) Fixed nine-bit rate is clock/64 or /32
// (RULE_03) Reception only while receive enable set; a shift-mode byte already started still completes after it clears
// (RULE_04) Control bit 3 sent as ninth bit
// (RULE_05) Ninth received bit captured into bit 2
// (RULE_06) Transmit-complete flag set, cleared by software
// (RULE_07) Receive-complete flag set, cleared by software
// (RULE_08) Data buffer write starts transmission
// (RULE_09) Data buffer read returns received byte
// (RULE_10) Reload value is ten bits wide
// (RULE_11) Source bit picks generator or timer overflow
// (RULE_12) Generator rate uses 64 times (1024-reload)
// (RULE_13) Rate-double flag doubles both rates
// (RULE_14) All timing derived from core clock
// (RULE_15) Software should prefer the internal generator
// (RULE_16) Start bit, data LSB first, stop bit
// (RULE_17) Shift mode: clock on transmit, data on receive
module spu_uart (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic rate_double_i,
	input wire logic timer1_overflow_i,
	input wire logic rx_line_i,
	output logic rx_line_o,
	output logic rx_line_oe_o,
	output logic tx_line_o,
	output logic irq_o
);

	spu_pkg::spu_state_type s;
	spu_pkg::spu_state_type next_s;
	logic tick16;
	logic half;
	logic [1:0] mode;
	logic nine;

	assign mode = s.ctrl[`SPU_MODE_HI:`SPU_MODE_LO];
	assign nine = s.ctrl[`SPU_MODE_HI];

	// ----------------------------------------
	// Bit rate generator
	// ----------------------------------------
	spu_baud u_baud (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.mode_i(mode),
		.rate_double_i(rate_double_i),
		.internal_sel_i(s.src_int),
		.reload_i({s.rel_high[`SPU_REL_HIGH_MSB:0], s.rel_low}),
		.timer1_overflow_i(timer1_overflow_i),
		.tick16_o(tick16),
		.half_o(half)
	);

	function automatic logic [3:0] last_bit(input logic ninth_mode);
		last_bit = ninth_mode ? `SPU_BITS_9 : `SPU_BITS_8;
	endfunction

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.rdata = 8'h00;

		// Register writes
		if (wr_i) begin
			if (addr_i == `SPU_ADDR_CTRL) begin
				next_s.ctrl = wdata_i; // RULE_06 RULE_07
			end else if (addr_i == `SPU_ADDR_DATA) begin
				next_s.tx_shift = {s.ctrl[`SPU_TX_NINTH], wdata_i}; // RULE_04
				next_s.tx_ph = 4'h0;
				next_s.tx_bits = 4'h0;
				next_s.shift_rx = 1'b0;
				if (mode == 2'(spu_pkg::SPU_MODE_SHIFT)) begin
					next_s.tx_state = spu_pkg::TX_SHIFT;
				end else begin
					next_s.tx_state = spu_pkg::TX_START; // RULE_08
				end
			end else if (addr_i == `SPU_ADDR_IRQ_STAT) begin
				next_s.irq_stat = s.irq_stat & ~wdata_i[1:0];
			end else if (addr_i == `SPU_ADDR_IRQ_MASK) begin
				next_s.irq_mask = wdata_i[1:0];
			end else if (addr_i == `SPU_ADDR_REL_LOW) begin
				next_s.rel_low = wdata_i; // RULE_10
			end else if (addr_i == `SPU_ADDR_REL_HIGH) begin
				next_s.rel_high = wdata_i;
			end else if (addr_i == `SPU_ADDR_SRC_SEL) begin
				next_s.src_int = wdata_i[`SPU_SRC_INT]; // RULE_11
			end
		end

		// Register reads, data one cycle later
		if (rd_i) begin
			if (addr_i == `SPU_ADDR_CTRL) begin
				next_s.rdata = s.ctrl;
			end else if (addr_i == `SPU_ADDR_DATA) begin
				next_s.rdata = s.rx_buf; // RULE_09
			end else if (addr_i == `SPU_ADDR_IRQ_STAT) begin
				next_s.rdata = {6'h00, s.irq_stat};
			end else if (addr_i == `SPU_ADDR_IRQ_MASK) begin
				next_s.rdata = {6'h00, s.irq_mask};
			end else if (addr_i == `SPU_ADDR_REL_LOW) begin
				next_s.rdata = s.rel_low;
			end else if (addr_i == `SPU_ADDR_REL_HIGH) begin
				next_s.rdata = s.rel_high;
			end else if (addr_i == `SPU_ADDR_SRC_SEL) begin
				next_s.rdata = {s.src_int, 7'h00};
			end
		end

		// Shift-register mode receive starts when enabled and the flag is clear
		if (mode == 2'(spu_pkg::SPU_MODE_SHIFT) && s.tx_state == spu_pkg::TX_IDLE
				&& s.ctrl[`SPU_RX_EN] && !s.ctrl[`SPU_RX_DONE] && !wr_i) begin
			next_s.tx_state = spu_pkg::TX_SHIFT; // RULE_03
			next_s.shift_rx = 1'b1;
			next_s.tx_ph = 4'h0;
			next_s.tx_bits = 4'h0;
		end

		// ----------------------------------------
		// Transmit engine
		// ----------------------------------------
		case (s.tx_state)
		spu_pkg::TX_IDLE: begin
			next_s.tx_line = 1'b1;
			next_s.rx_oe = 1'b0;
		end
		spu_pkg::TX_START: begin
			next_s.tx_line = 1'b0; // RULE_16
			if (tick16) begin
				next_s.tx_ph = s.tx_ph + 4'h1;
				if (s.tx_ph == `SPU_PH_END) begin
					next_s.tx_state = spu_pkg::TX_DATA;
				end
			end
		end
		spu_pkg::TX_DATA: begin
			next_s.tx_line = s.tx_shift[0]; // RULE_16
			if (tick16) begin
				next_s.tx_ph = s.tx_ph + 4'h1;
				if (s.tx_ph == `SPU_PH_END) begin
					next_s.tx_shift = {1'b1, s.tx_shift[8:1]};
					next_s.tx_bits = s.tx_bits + 4'h1;
					if (s.tx_bits == last_bit(nine)) begin
						next_s.tx_state = spu_pkg::TX_STOP;
						next_s.tx_line = 1'b1;
						next_s.ctrl[`SPU_TX_DONE] = 1'b1; // RULE_06
						next_s.irq_stat[`SPU_IRQ_TX] = 1'b1;
					end
				end
			end
		end
		spu_pkg::TX_STOP: begin
			next_s.tx_line = 1'b1; // RULE_16
			if (tick16) begin
				next_s.tx_ph = s.tx_ph + 4'h1;
				if (s.tx_ph == `SPU_PH_END) begin
					next_s.tx_state = spu_pkg::TX_IDLE;
				end
			end
		end
		spu_pkg::TX_SHIFT: begin
			// Shift clock low in the first half of a bit, high in the second
			next_s.rx_oe = !s.shift_rx; // RULE_17
			next_s.rx_line = s.tx_shift[0];
			next_s.tx_line = s.tx_ph[0];
			// The first half tick is skipped until the clock is low, so no low phase is lost
			if (half && s.tx_line == s.tx_ph[0]) begin
				next_s.tx_ph = {3'h0, ~s.tx_ph[0]};
				next_s.tx_line = ~s.tx_ph[0]; // RULE_01
				if (!s.tx_ph[0]) begin
					if (s.shift_rx) begin
						next_s.rx_shift = {1'b0, rx_line_i, s.rx_shift[7:1]}; // RULE_17
					end
				end else begin
					next_s.tx_shift = {1'b1, s.tx_shift[8:1]};
					next_s.rx_line = s.tx_shift[1];
					next_s.tx_bits = s.tx_bits + 4'h1;
					if (s.tx_bits == `SPU_BITS_8) begin
						next_s.tx_state = spu_pkg::TX_IDLE;
						next_s.tx_line = 1'b1;
						next_s.rx_oe = 1'b0;
						if (s.shift_rx) begin
							next_s.rx_buf = s.rx_shift[7:0];
							next_s.ctrl[`SPU_RX_DONE] = 1'b1; // RULE_07
							next_s.irq_stat[`SPU_IRQ_RX] = 1'b1;
						end else begin
							next_s.ctrl[`SPU_TX_DONE] = 1'b1; // RULE_06
							next_s.irq_stat[`SPU_IRQ_TX] = 1'b1;
						end
					end
				end
			end
		end
		default: begin
			next_s.tx_state = spu_pkg::TX_IDLE;
		end
		endcase

		// ----------------------------------------
		// UART receive engine
		// ----------------------------------------
		next_s.rx_prev = rx_line_i;
		case (s.rx_state)
		spu_pkg::RX_IDLE: begin
			if (mode != 2'(spu_pkg::SPU_MODE_SHIFT) && s.ctrl[`SPU_RX_EN]
					&& s.rx_prev && !rx_line_i) begin
				next_s.rx_state = spu_pkg::RX_START; // RULE_03
				next_s.rx_ph = 4'h0;
				next_s.rx_bits = 4'h0;
			end
		end
		spu_pkg::RX_START: begin
			if (tick16) begin
				next_s.rx_ph = s.rx_ph + 4'h1;
				if (s.rx_ph == `SPU_PH_MID && rx_line_i) begin
					next_s.rx_state = spu_pkg::RX_IDLE;
				end else if (s.rx_ph == `SPU_PH_END) begin
					next_s.rx_state = spu_pkg::RX_DATA; // RULE_16
				end
			end
		end
		spu_pkg::RX_DATA: begin
			if (tick16) begin
				next_s.rx_ph = s.rx_ph + 4'h1;
				if (s.rx_ph == `SPU_PH_MID) begin
					next_s.rx_shift = {rx_line_i, s.rx_shift[8:1]}; // RULE_16
				end else if (s.rx_ph == `SPU_PH_END) begin
					next_s.rx_bits = s.rx_bits + 4'h1;
					if (s.rx_bits == last_bit(nine)) begin
						next_s.rx_state = spu_pkg::RX_STOP;
					end
				end
			end
		end
		spu_pkg::RX_STOP: begin
			if (tick16) begin
				next_s.rx_ph = s.rx_ph + 4'h1;
				if (s.rx_ph == `SPU_PH_MID) begin
					next_s.rx_state = spu_pkg::RX_IDLE;
					if (nine) begin
						next_s.rx_buf = s.rx_shift[7:0];
						next_s.ctrl[`SPU_RX_NINTH] = s.rx_shift[8]; // RULE_05
					end else begin
						next_s.rx_buf = s.rx_shift[8:1];
					end
					next_s.ctrl[`SPU_RX_DONE] = 1'b1; // RULE_07
					next_s.irq_stat[`SPU_IRQ_RX] = 1'b1;
				end
			end
		end
		default: begin
			next_s.rx_state = spu_pkg::RX_IDLE;
		end
		endcase

		// A frame in progress is dropped once reception is disabled
		if (!s.ctrl[`SPU_RX_EN]) begin
			next_s.rx_state = spu_pkg::RX_IDLE; // RULE_03
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			s <= '0;
			s.tx_state <= spu_pkg::TX_IDLE;
			s.rx_state <= spu_pkg::RX_IDLE;
			s.ctrl <= `SPU_RST_CTRL;
			s.rx_buf <= `SPU_RST_DATA;
			s.rel_low <= `SPU_RST_REL_LOW;
			s.rel_high <= `SPU_RST_REL_HIGH;
			s.src_int <= 1'(`SPU_RST_SRC_SEL >> `SPU_SRC_INT);
			s.irq_stat <= `SPU_RST_IRQ;
			s.irq_mask <= `SPU_RST_IRQ;
			s.rx_prev <= 1'b1;
			s.tx_line <= 1'b1;
			s.rx_line <= 1'b1;
		end else begin
			s <= next_s; // RULE_14
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata_o = s.rdata;
	assign tx_line_o = s.tx_line;
	assign rx_line_o = s.rx_line;
	assign rx_line_oe_o = s.rx_oe;
	assign irq_o = |(s.irq_stat & s.irq_mask);

endmodule

// ===== bench/spu_uart_asserts.sv
// Checker for the serial port register port and line timing.
// Assumes it is bound to spu_uart and sees only its ports.
`timescale 1ns/1ps
module spu_uart_asserts (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic rate_double_i,
	input wire logic rx_line_oe_o,
	input wire logic tx_line_o,
	input wire logic irq_o
);
	logic [1:0] mode;
	logic [1:0] mask;
	logic [7:0] rell;
	logic [7:0] relh;
	logic src;
	logic prev;
	int run;
	int per;
	// ----
	// Shadow of software settings and transmit line run length
	// ----
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			mode <= 2'h0;
			mask <= 2'h0;
			rell <= 8'hd9;
			relh <= 8'h03;
			src <= 1'b0;
			prev <= 1'b1;
			run <= 0;
		end else begin
			if (wr_i) begin
				case (addr_i)
					8'h98: mode <= wdata_i[7:6];
					8'h9b: mask <= wdata_i[1:0];
					8'haa: rell <= wdata_i;
					8'hba: relh <= wdata_i;
					8'hd8: src <= wdata_i[7];
					default: ;
				endcase
			end
			prev <= tx_line_o;
			run <= (tx_line_o != prev) ? 1 : run + 1;
		end
	end
	always_comb begin
		per = 0;
		if (mode == 2'h2)
			per = 64;
		else if (src)
			per = 64 * (1024 - int'({relh[1:0], rell}));
		per = per >> rate_double_i;
	end
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);
	sequence s_dwr;
		wr_i && addr_i == 8'h99;
	endsequence
	sequence s_rise;
		$rose(tx_line_o);
	endsequence
	AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	AST_TX_START: assert property (s_dwr ##0 (mode != 2'h0) |=> ##1 !tx_line_o)
		else $error("no start bit after data write");
	AST_SHIFT_OE: assert property (s_dwr ##0 (mode == 2'h0) |=> ##1 rx_line_oe_o)
		else $error("shift data not driven after write");
	AST_SHIFT_HIGH: assert property (s_rise ##0 (mode == 2'h0) |-> tx_line_o [*6])
		else $error("shift clock high phase short");
	AST_BIT_RUN: assert property (s_rise ##0 (mode != 2'h0 && per > 0) |->
		run % per == 0 || run % per >= per - per / 16) else $error("bit time wrong");
	AST_IRQ_MASK: assert property (mask == 2'h0 |-> !irq_o)
		else $error("interrupt while all masked");
	AST_SRC_READ: assert property (rd_i && addr_i == 8'hd8 |=> rdata_o == {src, 7'h00})
		else $error("source select readback wrong");
	AST_REL_READ: assert property (rd_i && addr_i == 8'hba |=> rdata_o == relh)
		else $error("reload high readback wrong");
endmodule

bind spu_uart spu_uart_asserts chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.rate_double_i(rate_double_i), .rx_line_oe_o(rx_line_oe_o), .tx_line_o(tx_line_o),
	.irq_o(irq_o));

// ===== bench/spu_remote.sv
// Remote serial device: sends frames, samples frames and shift data.
// Assumes one clock shared with the device; bit times are given in clocks.
`timescale 1ns/1ps
module spu_remote (
	input wire logic clk_i,
	input wire logic tx_i,
	input wire logic dat_i,
	output logic line_o
);
	initial line_o = 1'b1;
	// ----
	// Frame tasks
	// ----
	task automatic hold(input logic v);
		int k;
		k = 0;
		while (tx_i == v && k < 999) begin
			@(posedge clk_i);
			k++;
		end
	endtask
	task automatic send(input logic [8:0] d, input int n, input int per);
		line_o <= 1'b0;
		repeat (per) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			line_o <= d[i];
			repeat (per) @(posedge clk_i);
		end
		line_o <= 1'b1;
		repeat (per) @(posedge clk_i);
	endtask
	task automatic get(output logic [8:0] d, input int n, input int per);
		d = 9'h000;
		hold(1'b1);
		repeat (per / 2) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			repeat (per) @(posedge clk_i);
			d[i] = tx_i;
		end
	endtask
	task automatic sget(output logic [8:0] d);
		d = 9'h000;
		for (int i = 0; i < 8; i++) begin
			hold(1'b1);
			hold(1'b0);
			d[i] = dat_i;
		end
	endtask
endmodule

// ===== bench/tb.sv
// Self-checking bench for the serial port: registers, framing, flags.
// Assumes design, checker and remote device model are compiled first.
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rdbl = 1'b0;
	logic t1 = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [7:0] ra [7] = '{8'h98, 8'h99, 8'haa, 8'hba, 8'hd8, 8'h9a, 8'h9c};
	logic [7:0] rv [7] = '{8'h00, 8'h00, 8'hd9, 8'h03, 8'h00, 8'h00, 8'h00};
	logic [8:0] got;
	logic rxo, rxoe, txl, irq, rline;
	wire logic rxw;
	int n_mismatch = 0;
	int check_count = 0;
	assign rxw = rxoe ? rxo : rline;
	always #2 clk = ~clk;
	always @(posedge clk) t1 <= ~t1;
	spu_uart dut (.core_clk_i(clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rate_double_i(rdbl),
		.timer1_overflow_i(t1), .rx_line_i(rxw), .rx_line_o(rxo), .rx_line_oe_o(rxoe),
		.tx_line_o(txl), .irq_o(irq));
	spu_remote rem (.clk_i(clk), .tx_i(txl), .dat_i(rxw), .line_o(rline));
	// ----
	// Access and compare tasks
	// ----
	task automatic chk(input string s, input logic [8:0] e, input logic [8:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk($sformatf("register %h", a), {1'b0, e}, {1'b0, rdata});
	endtask
	task automatic txf(input logic [7:0] c, input logic [7:0] d, input int n, input int p,
		input logic [8:0] e);
		wr_reg(8'h98, c);
		fork
			rem.get(got, n, p);
			wr_reg(8'h99, d);
		join
		repeat (p) @(posedge clk);
		chk("serial frame", e, got);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		finish_test;
	end
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		foreach (ra[i]) rd_reg(ra[i], rv[i]);
		wr_reg(8'hba, 8'hff);
		rd_reg(8'hba, 8'hff);
		wr_reg(8'hd8, 8'hff);
		rd_reg(8'hd8, 8'h80);
		wr_reg(8'hd8, 8'h00);
		txf(8'h88, 8'ha5, 9, 64, 9'h1a5);
		rd_reg(8'h98, 8'h8a);
		rd_reg(8'h9a, 8'h02);
		chk("irq", 9'h000, {8'h00, irq});
		wr_reg(8'h9b, 8'h02);
		#1 chk("irq", 9'h001, {8'h00, irq});
		wr_reg(8'h9a, 8'h02);
		#1 chk("irq", 9'h000, {8'h00, irq});
		rd_reg(8'h98, 8'h8a);
		wr_reg(8'hd8, 8'h80);
		wr_reg(8'haa, 8'hfe);
		txf(8'hc0, 8'h81, 9, 128, 9'h081);
		rdbl <= 1'b1;
		txf(8'hc8, 8'h42, 9, 64, 9'h142);
		txf(8'h80, 8'h3c, 9, 32, 9'h03c);
		wr_reg(8'hd8, 8'h00);
		txf(8'h40, 8'h96, 8, 32, 9'h096);
		rdbl <= 1'b0;
		wr_reg(8'h98, 8'h00);
		fork
			rem.sget(got);
			wr_reg(8'h99, 8'h6b);
		join
		chk("shift data", 9'h06b, got);
		repeat (8) @(posedge clk);
		rd_reg(8'h98, 8'h02);
		wr_reg(8'h98, 8'h90);
		wr_reg(8'h9b, 8'h01);
		rem.send(9'h15a, 9, 64);
		rd_reg(8'h98, 8'h95);
		rd_reg(8'h99, 8'h5a);
		chk("irq", 9'h001, {8'h00, irq});
		wr_reg(8'h98, 8'h80);
		rem.send(9'h0a5, 9, 64);
		rd_reg(8'h98, 8'h80);
		rd_reg(8'h99, 8'h5a);
		finish_test;
	end
endmodule
